// ==== verilog/sac_pkg.sv ====
// Constants and carrier types for the step attenuator control block.
// Assumes a 20 MHz system clock and a controller-driven shift clock on the link.
`default_nettype none

package sac_pkg;

    // ----------------------------------------------------------------
    // Attenuation word
    // ----------------------------------------------------------------
    localparam int WORD_W = 7;
    localparam logic [6:0] ATTEN_MAX = 7'h7f;     // All stages in, 31.75 dB
    localparam logic [6:0] ATTEN_REF = 7'h00;     // Reference state
    localparam int STEP_HUNDREDTHS_DB = 25;       // Weight of the LSB, 0.25 dB
    localparam int DB_W = 12;                     // Wide enough for 3175
    localparam logic [11:0] FULL_SCALE_HUNDREDTHS = 12'hc67;  // 31.75 dB
    localparam logic [6:0] SHIFT_RESET = 7'h7f;   // Shift register content after reset

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_HZ = 20_000_000;
    localparam int PWRUP_SETTLE_MS = 200;
    localparam int PWRUP_SETTLE_CYCLES = PWRUP_SETTLE_MS * (CLK_HZ / 1000);
    localparam int SETTLE_W = 23;

    // ----------------------------------------------------------------
    // Control mode as seen by the applying logic
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        SAC_MODE_SERIAL,
        SAC_MODE_PAR_DIRECT,
        SAC_MODE_PAR_LATCHED
    } sac_mode_t;

    // Synchronised control pins, carried together
    typedef struct packed {
        logic serial_mode;
        logic latch_enable;
        logic [6:0] parallel_atten_bits;
    } sac_ctl_t;

endpackage : sac_pkg

`default_nettype wire

// ==== verilog/sac_step_attenuator_control.sv ====
// Control front end of a 7-bit step attenuator: serial shift path on the
// controller's shift clock, parallel path, latch and power-up hold on clk.
// Assumes the controller keeps every control pin at a defined level and
// changes serial data and latch enable with setup to the shift clock.
//
// Summary of operation
// - A high mode-select level chooses serial control and a low level chooses parallel control, never left floating.
// - The block holds a 7-bit word giving 0 to 31.75 dB in 0.25 dB steps.
// - In either mode the applied word changes only under control of latch enable.
// - The three-wire serial path (data, shift clock, latch enable) works only while mode-select is high.
// - Serial data is sampled on each rising shift-clock edge into a 7-bit shift register, MSB first.
// - After seven bits the controller raises latch enable and the shift word becomes the applied word.
// - While latch enable is high the shift clock is ignored, so shifting needs latch enable low.
// - Bit 6 weighs 16 dB, then 8, 4, 2, 1, 0.5, and bit 0 weighs 0.25 dB.
// - The applied attenuation is the sum of the weights of the set bits, all zero being the reference.
// - With mode-select low there are two parallel sub-modes, direct and latched, set by latch enable use.
// - For direct parallel operation the controller holds latch enable high all the time.
// - In direct parallel operation the parallel lines reach the applied word without any latch pulse.
// - In latched parallel operation a high latch enable passes the lines through and a low one holds them.
// - The block starts at maximum attenuation and takes up the requested state about 200 ms after power-up in direct mode, else at the next latch enable rise.
`timescale 1ns/10ps
`default_nettype none

module sac_step_attenuator_control #(
    parameter int SETTLE_CYCLES = sac_pkg::PWRUP_SETTLE_CYCLES
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic shift_clk,
    input wire logic serial_mode,
    input wire logic serial_data_in,
    input wire logic latch_enable,
    input wire logic [6:0] parallel_atten_bits,
    output logic [6:0] atten_state,
    output logic [11:0] atten_hundredths_db,
    output logic power_up_done
);

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------

    // Attenuation in hundredths of a dB: each code step is one LSB weight
    function automatic logic [11:0] sac_hundredths(input logic [6:0] code);
        logic [11:0] acc;
        acc = 12'h000;
        for (int i = 0; i < sac_pkg::WORD_W; i++)
        begin
            if (code[i])
                acc = acc + 12'(sac_pkg::STEP_HUNDREDTHS_DB << i);
        end
        return acc;
    endfunction : sac_hundredths

    // ----------------------------------------------------------------
    // Link domain: shift register on the controller's shift clock
    // ----------------------------------------------------------------

    // Pins here are timed by the controller against shift_clk itself,
    // so they are used directly; no edge counts outside a shift burst
    logic [6:0] shift_q;
    logic [6:0] shift_d;

    // Shift is masked by latch enable and by parallel mode
    always_comb
    begin
        shift_d = shift_q;
        if (serial_mode && !latch_enable)
            shift_d = {shift_q[5:0], serial_data_in};
    end

    // Older bits fall off the top, so a long burst keeps the last seven
    always_ff @(posedge shift_clk or posedge reset)
    begin
        if (reset)
            shift_q <= sac_pkg::SHIFT_RESET;
        else
            shift_q <= shift_d;
    end

    // ----------------------------------------------------------------
    // Pin synchronisers into the clk domain
    // ----------------------------------------------------------------
    sac_pkg::sac_ctl_t ctl_meta_q;
    sac_pkg::sac_ctl_t ctl_sync_q;
    logic le_prev_q;

    // First stage feeds only the second stage. Each parallel bit is synced
    // on its own, so in direct mode a word that changes near a clk edge may
    // show a mix of old and new bits for one cycle; latched use avoids this
    // because the bits are still by the time latch enable is seen high
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            ctl_meta_q <= '0;
            ctl_sync_q <= '0;
        end
        else
        begin
            ctl_meta_q <= '{serial_mode, latch_enable, parallel_atten_bits};
            ctl_sync_q <= ctl_meta_q;
        end
    end

    // Edge memory for latch enable, taken from the settled stage
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            le_prev_q <= 1'b0;
        else
            le_prev_q <= ctl_sync_q.latch_enable;
    end

    logic le_rise;
    assign le_rise = ctl_sync_q.latch_enable && !le_prev_q;

    // ----------------------------------------------------------------
    // Power-up hold
    // ----------------------------------------------------------------
    logic [22:0] settle_q;
    logic settled_q;

    // Word stays at full attenuation until the settle time is over
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            settle_q <= '0;
            settled_q <= 1'b0;
        end
        else if (!settled_q)
        begin
            settle_q <= settle_q + 23'h000001;
            if (settle_q >= 23'(SETTLE_CYCLES - 1))
                settled_q <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // Mode decode and applied word
    // ----------------------------------------------------------------
    sac_pkg::sac_mode_t mode;
    logic [6:0] atten_q;
    logic [6:0] atten_d;

    // Latched and direct differ only in how long latch enable stays high
    always_comb
    begin
        if (ctl_sync_q.serial_mode)
            mode = sac_pkg::SAC_MODE_SERIAL;
        else if (ctl_sync_q.latch_enable)
            mode = sac_pkg::SAC_MODE_PAR_DIRECT;
        else
            mode = sac_pkg::SAC_MODE_PAR_LATCHED;
    end

    // The shift word is read only after latch enable has been seen high
    // through two stages; the shift clock is masked then, so it is still.
    // This qualified read is the whole domain crossing: the link side hands
    // over a word that cannot move while it is taken.
    // Cost: latch enable must stay high for at least three clk periods
    always_comb
    begin
        atten_d = atten_q;
        case (mode)
            sac_pkg::SAC_MODE_SERIAL:
            begin
                if (le_rise)
                    atten_d = shift_q;
            end
            sac_pkg::SAC_MODE_PAR_DIRECT:
                atten_d = ctl_sync_q.parallel_atten_bits;
            sac_pkg::SAC_MODE_PAR_LATCHED:
                atten_d = atten_q;
            default:
                atten_d = atten_q;
        endcase
        if (!settled_q)
            atten_d = sac_pkg::ATTEN_MAX;
    end

    // Applied attenuation word
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            atten_q <= sac_pkg::ATTEN_MAX;
        else
            atten_q <= atten_d;
    end

    // Reported attenuation, registered so it moves with the word
    logic [11:0] hdb_q;
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            hdb_q <= sac_pkg::FULL_SCALE_HUNDREDTHS;
        else
            hdb_q <= sac_hundredths(atten_d);
    end

    assign atten_state = atten_q;
    assign atten_hundredths_db = hdb_q;
    assign power_up_done = settled_q;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------

    chk_pwrup_max_hold: assert property (@(posedge clk) disable iff (reset)
        !settled_q |-> atten_q == sac_pkg::ATTEN_MAX)
        else $error("Word left full attenuation before settle time");

    chk_settle_count: assert property (@(posedge clk) disable iff (reset)
        (!settled_q && settle_q == 23'(SETTLE_CYCLES - 1)) |=> settled_q)
        else $error("Settle did not end at the settle count");

    chk_serial_latch_load: assert property (@(posedge clk) disable iff (reset)
        (settled_q && ctl_sync_q.serial_mode && le_rise) |=> atten_q == $past(shift_q))
        else $error("Latch rise in serial mode did not load the shift word");

    chk_le_low_hold: assert property (@(posedge clk) disable iff (reset)
        (settled_q && $past(settled_q) && !ctl_sync_q.latch_enable) |=> $stable(atten_q))
        else $error("Applied word moved while latch enable was low");

    chk_serial_no_rise_hold: assert property (@(posedge clk) disable iff (reset)
        (settled_q && ctl_sync_q.serial_mode && !le_rise) |=> $stable(atten_q))
        else $error("Serial mode word moved without a latch rise");

    chk_direct_follow: assert property (@(posedge clk) disable iff (reset)
        (settled_q && !ctl_sync_q.serial_mode && ctl_sync_q.latch_enable)
        |=> atten_q == $past(ctl_sync_q.parallel_atten_bits))
        else $error("Direct parallel word not applied");

    chk_shift_masked_le: assert property (@(posedge shift_clk) disable iff (reset)
        latch_enable |=> $stable(shift_q))
        else $error("Shift register moved while latch enable high");

    chk_shift_par_idle: assert property (@(posedge shift_clk) disable iff (reset)
        !serial_mode |=> $stable(shift_q))
        else $error("Shift register moved in parallel mode");

    chk_shift_msb_first: assert property (@(posedge shift_clk) disable iff (reset)
        (serial_mode && !latch_enable)
        |=> shift_q == {$past(shift_q[5:0]), $past(serial_data_in)})
        else $error("Serial bit not shifted in at the bottom");

    chk_weight_sum: assert property (@(posedge clk) disable iff (reset)
        (atten_q == sac_pkg::ATTEN_MAX |-> hdb_q == sac_pkg::FULL_SCALE_HUNDREDTHS)
        and (atten_q == sac_pkg::ATTEN_REF |-> hdb_q == 12'h000))
        else $error("Reported attenuation does not match the word");

    // Every code step is one LSB weight, so the sum is code times the step
    chk_db_tracks_word: assert property (@(posedge clk) disable iff (reset)
        hdb_q == 12'(atten_q) * 12'(sac_pkg::STEP_HUNDREDTHS_DB))
        else $error("Reported attenuation is not the weighted sum");

    // 16 dB on the top stage, 0.25 dB on the bottom one
    chk_stage_weights: assert property (@(posedge clk) disable iff (reset)
        (atten_q == 7'h40 |-> hdb_q == 12'h640)
        and (atten_q == 7'h01 |-> hdb_q == 12'h019))
        else $error("Stage weight of the top or bottom bit is wrong");

    chk_latched_hold: assert property (@(posedge clk) disable iff (reset)
        (settled_q && !ctl_sync_q.serial_mode && !ctl_sync_q.latch_enable) |=> $stable(atten_q))
        else $error("Latched parallel word moved with latch enable low");

    chk_serial_par_ignored: assert property (@(posedge clk) disable iff (reset)
        (settled_q && ctl_sync_q.serial_mode && !le_rise && $changed(ctl_sync_q.parallel_atten_bits))
        |=> $stable(atten_q))
        else $error("Parallel lines moved the word in serial mode");

    chk_settle_not_early: assert property (@(posedge clk) disable iff (reset)
        (!settled_q && settle_q < 23'(SETTLE_CYCLES - 1)) |=> !settled_q)
        else $error("Power-up hold ended before the settle count");

    chk_done_sticky: assert property (@(posedge clk) disable iff (reset)
        settled_q |=> settled_q)
        else $error("Power-up done fell without a reset");

    // ----------------------------------------------------------------
    // Main scenarios
    // ----------------------------------------------------------------
    cov_serial_load: cover property (@(posedge clk) disable iff (reset)
        settled_q && ctl_sync_q.serial_mode && le_rise ##1 atten_q != sac_pkg::ATTEN_MAX);

    cov_direct_mode: cover property (@(posedge clk) disable iff (reset)
        settled_q && mode == sac_pkg::SAC_MODE_PAR_DIRECT);

    cov_latched_pulse: cover property (@(posedge clk) disable iff (reset)
        settled_q && !ctl_sync_q.serial_mode && le_rise ##[1:20] !ctl_sync_q.latch_enable);

    cov_settle_done: cover property (@(posedge clk) disable iff (reset)
        !settled_q ##1 settled_q);

    cov_mode_switch: cover property (@(posedge clk) disable iff (reset)
        settled_q && !ctl_sync_q.serial_mode ##1 ctl_sync_q.serial_mode);

endmodule : sac_step_attenuator_control

`default_nettype wire

// ==== testbench/sac_ctl_model.sv ====
// Controller model that shifts serial words on its own 12 ns shift clock.
// Assumes the bench raises go for one clk and holds nbits and word meanwhile.
`timescale 1ns/10ps
`default_nettype none

module sac_ctl_model (
    input wire logic go,
    input wire logic [3:0] nbits,
    input wire logic [13:0] word,
    output logic shift_clk,
    output logic serial_data_in,
    output logic busy
);
    int i;

    // One process owns every output; the clock only runs inside a frame
    // and its offset keeps its edges apart from rising clk edges
    initial
    begin
        shift_clk = 1'b0;
        serial_data_in = 1'b0;
        busy = 1'b0;
        forever
        begin
            @(posedge go);
            busy = 1'b1;
            #3;
            for (i = int'(nbits) - 1; i >= 0; i--)
            begin
                serial_data_in = word[i];  // Highest bit goes out first
                #6 shift_clk = 1'b1;
                #6 shift_clk = 1'b0;
            end
            serial_data_in = ~serial_data_in;  // Stale bit must not look valid
            busy = 1'b0;
        end
    end
endmodule : sac_ctl_model

`default_nettype wire

// ==== testbench/sac_step_attenuator_control_tb.sv ====
// Self-checking bench for the step attenuator control block.
// Assumes sac_ctl_model drives the shift clock and serial data.
`timescale 1ns/10ps
`default_nettype none

module sac_step_attenuator_control_tb;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic serial_mode = 1'b0;
    logic latch_enable = 1'b1;
    logic [6:0] parallel_atten_bits = 7'h00;
    logic go = 1'b0;
    logic [3:0] nbits = 4'h7;
    logic [13:0] word = 14'h0000;
    logic shift_clk;
    logic serial_data_in;
    logic busy;
    logic [6:0] atten_state;
    logic [11:0] atten_hundredths_db;
    logic power_up_done;
    int errors = 0;
    int checked = 0;
    int cycles = 0;

    // Short settle count keeps the power-up hold visible in a short run
    localparam int SETTLE_SIM = 16;

    always #25 clk = ~clk;

    sac_step_attenuator_control #(.SETTLE_CYCLES(SETTLE_SIM)) dut_u (
        .clk(clk), .reset(reset), .shift_clk(shift_clk), .serial_mode(serial_mode),
        .serial_data_in(serial_data_in), .latch_enable(latch_enable),
        .parallel_atten_bits(parallel_atten_bits), .atten_state(atten_state),
        .atten_hundredths_db(atten_hundredths_db), .power_up_done(power_up_done)
    );

    sac_ctl_model ctl_u (
        .go(go), .nbits(nbits), .word(word), .shift_clk(shift_clk),
        .serial_data_in(serial_data_in), .busy(busy)
    );

    task automatic cmp_val(input string what, input logic [11:0] exp, input logic [11:0] got);
        checked++;
        if (got !== exp)
        begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp_val

    task automatic check_applied(input logic [6:0] exp);
        cmp_val("atten_state", {5'h00, exp}, {5'h00, atten_state});
        cmp_val("atten_db", 12'(exp) * 12'h019, atten_hundredths_db);
    endtask : check_applied

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : give_verdict

    // Hang guard: the whole sequence needs well under this many cycles
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 3000)
        begin
            errors++;
            give_verdict();
        end
    end

    task automatic send(input logic [3:0] n, input logic [13:0] w);
        int k;
        @(posedge clk);
        nbits <= n;
        word <= w;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        k = 0;
        while (busy !== 1'b0 && k < 10)
        begin
            @(posedge clk);
            k++;
        end
        cmp_val("frame_done", 12'h000, {11'h000, busy});
    endtask : send

    // Pulse spacing of six cycles clears the two-stage sync with margin
    task automatic pulse_latch;
        @(posedge clk);
        latch_enable <= 1'b1;
        repeat (6) @(posedge clk);
        latch_enable <= 1'b0;
        repeat (6) @(posedge clk);
        #1;
    endtask : pulse_latch

    task automatic t_powerup;
        int k;
        repeat (8) @(posedge clk);
        #1;
        check_applied(7'h7f);
        cmp_val("power_up_done", 12'h000, {11'h000, power_up_done});
        k = 0;
        while (power_up_done !== 1'b1 && k < 30)
        begin
            @(posedge clk);
            #1;
            k++;
        end
        cmp_val("power_up_done", 12'h001, {11'h000, power_up_done});
        cmp_val("settle_edges", 12'(SETTLE_SIM - 8), 12'(k));
        $display("test powerup done");
    endtask : t_powerup

    task automatic t_direct;
        logic [6:0] v;
        for (int k = 0; k < 8; k++)
        begin
            v = (k == 7) ? 7'h7f : 7'(1 << k);
            @(posedge clk);
            parallel_atten_bits <= v;
            repeat (4) @(posedge clk);
            #1;
            check_applied(v);
        end
        $display("test direct done");
    endtask : t_direct

    task automatic t_latched;
        @(posedge clk);
        latch_enable <= 1'b0;
        repeat (4) @(posedge clk);
        parallel_atten_bits <= 7'h55;
        repeat (6) @(posedge clk);
        #1;
        check_applied(7'h7f);
        pulse_latch();
        check_applied(7'h55);
        @(posedge clk);
        parallel_atten_bits <= 7'h2a;
        repeat (6) @(posedge clk);
        #1;
        check_applied(7'h55);
        $display("test latched done");
    endtask : t_latched

    task automatic t_serial;
        @(posedge clk);
        parallel_atten_bits <= 7'h00;  // Unused lines tied low
        serial_mode <= 1'b1;
        repeat (4) @(posedge clk);
        send(4'h7, 14'h004b);
        repeat (4) @(posedge clk);
        #1;
        check_applied(7'h55);
        pulse_latch();
        check_applied(7'h4b);
        @(posedge clk);
        latch_enable <= 1'b1;
        repeat (4) @(posedge clk);
        send(4'h7, 14'h0011);
        @(posedge clk);
        latch_enable <= 1'b0;
        repeat (6) @(posedge clk);
        pulse_latch();
        check_applied(7'h4b);
        $display("test serial done");
    endtask : t_serial

    task automatic t_extra;
        send(4'h9, 14'h0135);
        pulse_latch();
        check_applied(7'h35);
        @(posedge clk);
        serial_mode <= 1'b0;
        repeat (4) @(posedge clk);
        send(4'h7, 14'h000f);
        @(posedge clk);
        serial_mode <= 1'b1;
        repeat (4) @(posedge clk);
        pulse_latch();
        check_applied(7'h35);
        $display("test extra done");
    endtask : t_extra

    initial
    begin
        repeat (10) @(posedge clk);
        reset <= 1'b0;
        t_powerup();
        t_direct();
        t_latched();
        t_serial();
        t_extra();
        give_verdict();
    end
endmodule : sac_step_attenuator_control_tb

`default_nettype wire
